// >>> dv/irq_far_side.sv
// far side model: pin sources and a masking interrupt manager
`timescale 1ns/10ps
module irq_far_side (
  input wire logic clk,
  input wire logic [31:0] pin_cmd,
  input wire logic high_req,
  input wire logic low_req,
  input wire logic [1:0] mask,
  output logic [31:0] irq_pins,
  output logic cpu_irq
);
  always @(posedge clk) irq_pins <= pin_cmd;
  assign cpu_irq = |({high_req, low_req} & mask);
endmodule // irq_far_side

// >>> dv/pin_edge_interrupt_controller_bench.sv
// self-checking bench for the pin edge interrupt controller
`timescale 1ns/10ps
`include "pin_irq_consts.svh"
module pin_edge_interrupt_controller_bench;
  logic clk = 0, rst = 1, low_power = 0, emu_mode = 0, rd = 0, wr = 0;
  logic [1:0] mask = 2'h3;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, pin_cmd = '0, rdata, irq_pins;
  logic high_req, low_req, cpu_irq;
  int mismatches = 0, cmp_count = 0;
  pin_edge_interrupt_controller pin_edge_interrupt_controller_i (.*);
  irq_far_side irq_far_side_i (.*);
  // 20 ns clock
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // strobes last one cycle, then one idle clock so calls never retoggle them
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    cyc(1);
    wr = 0;
    cyc(1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    addr = a;
    rd = 1;
    cyc(1);
    rd = 0;
    chk(rdata, e);
    cyc(1);
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_reset;
    for (int o = 8; o <= 48; o += 4) rdc(8'(o), '0);
    wrr(`OFS_HIGH_INDEX, '1);
    rdc(`OFS_HIGH_INDEX, '0);
  endtask
  task automatic t_ctrl;
    wrr(`OFS_ENA_CLR, '1);
    rdc(`OFS_ENA_SET, '0);
    wrr(`OFS_ENA_SET, '1);
    rdc(`OFS_ENA_CLR, '1);
    wrr(`OFS_ENA_CLR, 32'h8000_0000);
    rdc(`OFS_ENA_SET, 32'h7fff_ffff);
    wrr(`OFS_ENA_SET, '0);
    rdc(`OFS_ENA_SET, 32'h7fff_ffff);
    wrr(`OFS_PRI_HIGH, '1);
    rdc(`OFS_PRI_LOW, '1);
    wrr(`OFS_PRI_LOW, 32'hffff_0000);
    rdc(`OFS_PRI_HIGH, 32'h0000_ffff);
    wrr(`OFS_POLARITY, 32'h0000_0001);
    rdc(`OFS_POLARITY, 32'h0000_0001);
    wrr(`OFS_BOTH_EDGE, 32'h0000_000c);
  endtask
  // pin 0 rises, pin 20 rises then falls
  task automatic t_edge;
    pin_cmd = 32'h0010_0001;
    cyc(3);
    pin_cmd = 32'h0000_0001;
    cyc(3);
    rdc(`OFS_FLAGS, 32'h0010_0001);
    chk({high_req, low_req, cpu_irq}, 3'h7);
    mask = 2'h0;
    cyc(1);
    chk(cpu_irq, 1'b0);
    mask = 2'h3;
    rdc(`OFS_HIGH_INDEX, 32'h0000_0001);
    rdc(`OFS_LOW_INDEX, 32'h0000_0015);
    cyc(1);
    rdc(`OFS_FLAGS, '0);
  endtask
  // debug reads must not acknowledge
  task automatic t_emu;
    pin_cmd = 32'h0000_000d;
    cyc(3);
    wrr(`OFS_FLAGS, '0);
    emu_mode = 1;
    rdc(`OFS_HIGH_INDEX, 32'h0000_0003);
    emu_mode = 0;
    rdc(`OFS_HIGH_MON, 32'h0000_0003);
    rdc(`OFS_FLAGS, 32'h0000_000c);
    rdc(`OFS_HIGH_INDEX, 32'h0000_0003);
    cyc(2);
    rdc(`OFS_HIGH_INDEX, 32'h0000_0004);
  endtask
  task automatic t_level;
    pin_cmd = 32'h0000_0005;
    cyc(3);
    rdc(`OFS_FLAGS, 32'h0000_0008);
    wrr(`OFS_FLAGS, 32'h0000_0008);
    rdc(`OFS_FLAGS, '0);
    low_power = 1;
    cyc(2);
    rdc(`OFS_FLAGS, 32'hffff_fffb);
  endtask
  // reset for four edges, then the scenarios
  initial begin
    cyc(4);
    rst = 0;
    t_reset;
    t_ctrl;
    t_edge;
    t_emu;
    t_level;
    end_of_test;
  end
  // watchdog far past the hundred or so cycles needed
  initial begin
    #100000;
    mismatches++;
    end_of_test;
  end
endmodule // pin_edge_interrupt_controller_bench

// >>> dv/pin_irq_assertions.sv
// port assertions for the pin interrupt controller
`timescale 1ns/10ps
`include "pin_irq_consts.svh"
module pin_irq_assertions #(parameter int PINS = 32) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic high_req,
  input wire logic low_req
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // plain read; a same-cycle write wins
  sequence s_rd(a);
    rd && !wr && addr == a;
  endsequence
  // write v to a, read b after one idle clock: bits of v show set or clear
  property p_back(a, b, on);
    logic [31:0] v;
    (wr && addr == a, v = wdata) ##2 s_rd(b) |=> (rdata & v) == (on ? v : 0);
  endproperty
  a_reset_clears: assert property ($fell(rst) |-> rdata == 0 && !high_req && !low_req)
    else $error("not clear after reset");
  a_pol_back: assert property (p_back(`OFS_POLARITY, `OFS_POLARITY, 1))
    else $error("polarity readback");
  a_ena_on: assert property (p_back(`OFS_ENA_SET, `OFS_ENA_CLR, 1))
    else $error("enable not set");
  a_ena_off: assert property (p_back(`OFS_ENA_CLR, `OFS_ENA_SET, 0))
    else $error("enable not cleared");
  a_pri_high: assert property (p_back(`OFS_PRI_HIGH, `OFS_PRI_LOW, 1))
    else $error("priority not high");
  a_pri_low: assert property (p_back(`OFS_PRI_LOW, `OFS_PRI_HIGH, 0))
    else $error("priority not low");
  a_req_quiet: assert property (
    (wr && addr == `OFS_ENA_CLR && &wdata) ##1 !wr |=> !high_req && !low_req)
    else $error("request with all disabled");
  a_index_top: assert property (
    rd && !wr && addr >= `OFS_HIGH_INDEX && addr <= `OFS_LOW_MON |=> rdata[31:6] == 0)
    else $error("index upper bits set");
endmodule // pin_irq_assertions
bind pin_edge_interrupt_controller pin_irq_assertions #(.PINS(PINS)) chk_i (.*);

// >>> src/lowest_pending.sv
// finds the lowest numbered pending request and encodes it as index plus one
`timescale 1ns/10ps
`include "pin_irq_consts.svh"
module lowest_pending
  import pin_irq_pkg::*;
#(
  parameter int PINS = 32
) (
  input wire logic [PINS-1:0] pending,
  output irq_code_t code,
  output logic [PINS-1:0] onehot
);

  // scan from the top so the lowest index wins last
  always_comb begin
    code = `CODE_NONE;
    onehot = '0;
    for (int i = PINS - 1; i >= 0; i--) begin
      if (pending[i]) begin
        code = irq_code_t'(i + 1);
        onehot = '0;
        onehot[i] = 1'b1;
      end
    end
  end

endmodule // lowest_pending

// >>> src/pin_edge_interrupt_controller.sv
// pin edge interrupt controller: detection, flags, enables, priority and offsets
`timescale 1ns/10ps
`include "pin_irq_consts.svh"
module pin_edge_interrupt_controller
  import pin_irq_pkg::*;
#(
  parameter int PINS = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [PINS-1:0] irq_pins,
  input wire logic low_power,
  input wire logic emu_mode,
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata,
  output logic high_req,
  output logic low_req
);

  // control state
  logic [PINS-1:0] both_edge_q, both_edge_d;
  logic [PINS-1:0] polarity_q, polarity_d;
  logic [PINS-1:0] enable_q, enable_d;
  logic [PINS-1:0] high_pri_q, high_pri_d;
  // event state
  logic [PINS-1:0] flags_q, flags_d;
  logic [PINS-1:0] pin_prev_q, pin_prev_d;
  // index registers with one-hot twins, so a read clears the flag it reports
  irq_code_t high_index_q, high_index_d;
  irq_code_t low_index_q, low_index_d;
  logic [PINS-1:0] high_sel_q, high_sel_d;
  logic [PINS-1:0] low_sel_q, low_sel_d;
  // output flops
  logic [31:0] rdata_q, rdata_d;
  logic high_req_q, high_req_d;
  logic low_req_q, low_req_d;
  // combinational helpers
  bus_phase_t phase;
  logic [PINS-1:0] rise, fall;
  logic [PINS-1:0] hit, high_pend, low_pend, high_one, low_one, ack_clr;
  irq_code_t high_code, low_code;

  // zero extend a pin vector to the bus width
  function automatic logic [31:0] widen(input logic [PINS-1:0] v);
    logic [31:0] r;
    r = '0;
    r[PINS-1:0] = v;
    return r;
  endfunction

  // index words carry the code in the low bits, the rest read zero
  function automatic logic [31:0] code_word(input irq_code_t c);
    return {{`CODE_PAD{1'b0}}, c};
  endfunction

  // a plain read of offset o outside debug; only such reads acknowledge
  function automatic logic is_ack_read(input bus_phase_t ph, input logic emu,
    input logic [7:0] a, input logic [7:0] o);
    return ph == ACC_READ && !emu && a == o;
  endfunction

  // bus phase for this cycle; a write beats a read if both are raised
  always_comb begin
    if (wr) begin
      phase = ACC_WRITE;
    end else if (rd) begin
      phase = ACC_READ;
    end else begin
      phase = ACC_IDLE;
    end
  end

  // pin history next value and raw transitions against the last sample
  always_comb begin
    pin_prev_d = irq_pins;
    rise = irq_pins & ~pin_prev_q;
    fall = ~irq_pins & pin_prev_q;
  end

  // transition detect
  // pins are sampled once per clock, so a level held one clock is seen
  // low power ignores both-edge select and keeps setting while the level holds
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (low_power) begin
        hit[i] = polarity_q[i] ? irq_pins[i] : ~irq_pins[i];
      end else if (both_edge_q[i]) begin
        hit[i] = rise[i] | fall[i];
      end else if (polarity_q[i]) begin
        hit[i] = rise[i];
      end else begin
        hit[i] = fall[i];
      end
    end
  end

  // group split and lowest index pick
  assign high_pend = flags_q & enable_q & high_pri_q;
  assign low_pend = flags_q & enable_q & ~high_pri_q;

  // high group pick
  lowest_pending #(
    .PINS(PINS)
  ) u_high_pick (
    .pending(high_pend),
    .code(high_code),
    .onehot(high_one)
  );

  // low group pick
  lowest_pending #(
    .PINS(PINS)
  ) u_low_pick (
    .pending(low_pend),
    .code(low_code),
    .onehot(low_one)
  );

  // acknowledge by index read
  // clears the flag the register shows, not the live pick, which may have
  // moved on since the register was loaded
  always_comb begin
    ack_clr = '0;
    if (is_ack_read(phase, emu_mode, addr, `OFS_HIGH_INDEX)) begin
      ack_clr = high_sel_q;
    end else if (is_ack_read(phase, emu_mode, addr, `OFS_LOW_INDEX)) begin
      ack_clr = low_sel_q;
    end
  end

  // control register and flag next state
  always_comb begin
    both_edge_d = both_edge_q;
    polarity_d = polarity_q;
    enable_d = enable_q;
    high_pri_d = high_pri_q;
    flags_d = flags_q & ~ack_clr;
    // index and monitor offsets match no branch, so writes there are lost
    if (phase == ACC_WRITE) begin
      if (addr == `OFS_BOTH_EDGE) begin
        both_edge_d = wdata[PINS-1:0];
      end else if (addr == `OFS_POLARITY) begin
        polarity_d = wdata[PINS-1:0];
      end else if (addr == `OFS_ENA_SET) begin
        enable_d = enable_q | wdata[PINS-1:0];
      end else if (addr == `OFS_ENA_CLR) begin
        enable_d = enable_q & ~wdata[PINS-1:0];
      end else if (addr == `OFS_PRI_HIGH) begin
        high_pri_d = high_pri_q | wdata[PINS-1:0];
      end else if (addr == `OFS_PRI_LOW) begin
        high_pri_d = high_pri_q & ~wdata[PINS-1:0];
      end else if (addr == `OFS_FLAGS) begin
        flags_d = flags_d & ~wdata[PINS-1:0];
      end
    end
    // sticky set wins over any clear
    flags_d = flags_d | hit;
  end

  // index registers track pending codes
  // a normal read empties the register; the next pick reloads it after
  always_comb begin
    high_index_d = high_code;
    low_index_d = low_code;
    high_sel_d = high_one;
    low_sel_d = low_one;
    if (is_ack_read(phase, emu_mode, addr, `OFS_HIGH_INDEX)) begin
      high_index_d = `CODE_NONE;
      high_sel_d = '0;
    end
    if (is_ack_read(phase, emu_mode, addr, `OFS_LOW_INDEX)) begin
      low_index_d = `CODE_NONE;
      low_sel_d = '0;
    end
  end

  // read mux, registered; unmapped offsets read zero
  always_comb begin
    rdata_d = `REG_RESET;
    if (phase == ACC_READ) begin
      if (addr == `OFS_BOTH_EDGE) begin
        rdata_d = widen(both_edge_q);
      end else if (addr == `OFS_POLARITY) begin
        rdata_d = widen(polarity_q);
        // set and clear offsets both read back the live register
      end else if (addr == `OFS_ENA_SET || addr == `OFS_ENA_CLR) begin
        rdata_d = widen(enable_q);
      end else if (addr == `OFS_PRI_HIGH || addr == `OFS_PRI_LOW) begin
        rdata_d = widen(high_pri_q);
      end else if (addr == `OFS_FLAGS) begin
        rdata_d = widen(flags_q);
      end else if (addr == `OFS_HIGH_INDEX) begin
        rdata_d = code_word(high_index_q);
      end else if (addr == `OFS_LOW_INDEX) begin
        rdata_d = code_word(low_index_q);
      end else if (addr == `OFS_HIGH_MON) begin
        rdata_d = code_word(high_index_q);
      end else if (addr == `OFS_LOW_MON) begin
        rdata_d = code_word(low_index_q);
      end
    end
  end

  // request lines; masking is left to the manager
  // built from next values so a line rises with its flag, not a clock later
  always_comb begin
    high_req_d = |(flags_d & enable_d & high_pri_d);
    low_req_d = |(flags_d & enable_d & ~high_pri_d);
  end

  // control registers, all zero on reset
  always_ff @(posedge clk) begin
    if (rst) begin
      both_edge_q <= '0;
      polarity_q <= '0;
      enable_q <= '0;
      high_pri_q <= '0;
    end else begin
      both_edge_q <= both_edge_d;
      polarity_q <= polarity_d;
      enable_q <= enable_d;
      high_pri_q <= high_pri_d;
    end
  end

  // flags and pin history; a low history means a pin already high at
  // release counts as a rising edge on the first clock
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= '0;
      pin_prev_q <= '0;
    end else begin
      flags_q <= flags_d;
      pin_prev_q <= pin_prev_d;
    end
  end

  // index registers and their one-hot twins
  always_ff @(posedge clk) begin
    if (rst) begin
      high_index_q <= `CODE_NONE;
      low_index_q <= `CODE_NONE;
      high_sel_q <= '0;
      low_sel_q <= '0;
    end else begin
      high_index_q <= high_index_d;
      low_index_q <= low_index_d;
      high_sel_q <= high_sel_d;
      low_sel_q <= low_sel_d;
    end
  end

  // read data and request lines, registered so outputs leave flops
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= `REG_RESET;
      high_req_q <= 1'b0;
      low_req_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      high_req_q <= high_req_d;
      low_req_q <= low_req_d;
    end
  end

  // outputs straight from their flops
  assign rdata = rdata_q;
  assign high_req = high_req_q;
  assign low_req = low_req_q;

endmodule // pin_edge_interrupt_controller

// >>> src/pin_irq_consts.svh
// register offsets, reset values and field layout of the pin interrupt block
`ifndef PIN_IRQ_CONSTS_SVH
`define PIN_IRQ_CONSTS_SVH
`define OFS_BOTH_EDGE 8'h08
`define OFS_POLARITY 8'h0c
`define OFS_ENA_SET 8'h10
`define OFS_ENA_CLR 8'h14
`define OFS_PRI_HIGH 8'h18
`define OFS_PRI_LOW 8'h1c
`define OFS_FLAGS 8'h20
`define OFS_HIGH_INDEX 8'h24
`define OFS_LOW_INDEX 8'h28
`define OFS_HIGH_MON 8'h2c
`define OFS_LOW_MON 8'h30
`define REG_RESET 32'h0000_0000
`define CODE_NONE 6'h00
`define CODE_W 6
`define CODE_PAD 26
`endif

// >>> src/pin_irq_pkg.sv
// types shared by the pin interrupt block
package pin_irq_pkg;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'h0,
    ACC_READ = 2'h1,
    ACC_WRITE = 2'h3
  } bus_phase_t;
  typedef logic [5:0] irq_code_t;
endpackage
